// ---- vic_pkg.sv ----
package vic_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_LEVELS = 8;
  localparam int NUM_SOURCES = 31;
  localparam int LEVEL_W = 3;
  localparam int SRC_W = 5;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------------
  // constants of the service sequence
  // ----------------------------------------------------------------------
  localparam logic [VEC_W-1:0] VECTOR_PAGE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] PUSH_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] PUSH_TWO = 16'h0002;
  localparam logic [ADDR_W-1:0] PUSH_THREE = 16'h0003;
  localparam logic [NUM_SOURCES-1:0] AUTO_CLEAR_DEFAULT = 31'h0000_015E;

  // ----------------------------------------------------------------------
  // level priority register fields
  // ----------------------------------------------------------------------
  localparam int PRI_GROUP_B0 = 1;
  localparam int PRI_GROUP_B1 = 4;
  localparam int PRI_GROUP_B2 = 7;
  localparam int PRI_A_SEL = 0;
  localparam int PRI_B_SEL = 2;
  localparam int PRI_B_SUB = 3;
  localparam int PRI_C_SEL = 5;
  localparam int PRI_C_SUB = 6;
  localparam logic [2:0] ORDER_BCA = 3'h1;
  localparam logic [2:0] ORDER_BAC = 3'h3;
  localparam logic [2:0] ORDER_CAB = 3'h4;
  localparam logic [2:0] ORDER_CBA = 3'h5;
  localparam logic [2:0] ORDER_ACB = 3'h6;

  // ----------------------------------------------------------------------
  // source table, ascending vector address inside each level
  // ----------------------------------------------------------------------
  localparam logic [LEVEL_W-1:0] LEVEL_OF [0:NUM_SOURCES-1] = '{
    3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4,
    3'h5, 3'h5, 3'h5, 3'h5,
    3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6,
    3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
  localparam logic [VEC_W-1:0] VECTOR_OF [0:NUM_SOURCES-1] = '{
    8'hCE, 8'hD0, 8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hDA, 8'hDC, 8'hDE,
    8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE,
    8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE,
    8'hB0, 8'hB2, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC, 8'hBE};

  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic [SRC_W-1:0] source;
    logic [VEC_W-1:0] vector;
  } request_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
  } mem_cmd_type;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b000_0001,
    ST_PUSH_LO  = 7'b000_0010,
    ST_PUSH_HI  = 7'b000_0100,
    ST_PUSH_FL  = 7'b000_1000,
    ST_FETCH_HI = 7'b001_0000,
    ST_FETCH_LO = 7'b010_0000,
    ST_START    = 7'b100_0000
  } seq_state_type;

endpackage

// ---- vectored_interrupt_structure.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - there are eight levels 0 to 7, sharing one request output to the core.
// - level numbers are names only; the priority setting alone ranks them.
// - levels form groups and subgroups whose order the setting selects.
// - a level may own one or many vectors, up to eight each.
// - inside a level the lowest vector address wins, fixed in hardware.
// - thirty-one sources, each with its own vector over the eight levels.
// - a pending bit is cleared by software, or by hardware on service for sources whose auto-clear bit is set.
// - levels are one vector one source or many vectors many sources.
// - a grant disables interrupts and stacks the pc and the flags.
// - the service address is the vector byte then the next byte.
// - a source may be a pin event or a counter overflow.
// - enable and disable instructions drive bit 0 of system mode.
// - the mask register keeps a masked level from the core.
// - the request register holds one pending flag per level.
module vectored_interrupt_structure #(
  parameter logic [vic_pkg::NUM_SOURCES-1:0] AUTO_CLEAR =
    vic_pkg::AUTO_CLEAR_DEFAULT
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [vic_pkg::NUM_SOURCES-1:0] source_event_in,
  input wire logic [vic_pkg::NUM_SOURCES-1:0] source_clear_in,
  input wire logic [vic_pkg::NUM_LEVELS-1:0] level_mask_in,
  input wire logic [vic_pkg::NUM_LEVELS-1:0] level_priority_in,
  input wire logic enable_interrupts_in,
  input wire logic disable_interrupts_in,
  input wire logic grant_in,
  input wire logic [vic_pkg::ADDR_W-1:0] pc_in,
  input wire logic [vic_pkg::DATA_W-1:0] flags_in,
  input wire logic [vic_pkg::ADDR_W-1:0] sp_in,
  input wire logic [vic_pkg::DATA_W-1:0] mem_rdata_in,
  output logic request_valid_out,
  output vic_pkg::request_type request_out,
  output vic_pkg::mem_cmd_type mem_cmd_out,
  output logic [vic_pkg::ADDR_W-1:0] sp_out,
  output logic sp_load_out,
  output logic [vic_pkg::ADDR_W-1:0] service_addr_out,
  output logic service_start_out,
  output logic global_enable_out,
  output logic [vic_pkg::NUM_LEVELS-1:0] level_pending_out,
  output logic [vic_pkg::NUM_SOURCES-1:0] source_pending_out,
  output logic busy_out
);

  // ----------------------------------------------------------------------
  // level ranking
  // ----------------------------------------------------------------------
  // ranked list of levels, highest first in the top three bits
  function automatic logic [23:0] level_order(input logic [7:0] p);
    logic [5:0] ga;
    logic [8:0] gb;
    logic [8:0] gc;
    logic [5:0] sb;
    logic [5:0] sc;
    logic [2:0] code;
    ga = p[vic_pkg::PRI_A_SEL] ? {3'h1, 3'h0} : {3'h0, 3'h1};
    sb = p[vic_pkg::PRI_B_SUB] ? {3'h4, 3'h3} : {3'h3, 3'h4};
    gb = p[vic_pkg::PRI_B_SEL] ? {sb, 3'h2} : {3'h2, sb};
    sc = p[vic_pkg::PRI_C_SUB] ? {3'h7, 3'h6} : {3'h6, 3'h7};
    gc = p[vic_pkg::PRI_C_SEL] ? {sc, 3'h5} : {3'h5, sc};
    code = {p[vic_pkg::PRI_GROUP_B2], p[vic_pkg::PRI_GROUP_B1],
            p[vic_pkg::PRI_GROUP_B0]};
    // group order taken only from the setting
    case (code)
      vic_pkg::ORDER_BCA: level_order = {gb, gc, ga};
      vic_pkg::ORDER_BAC: level_order = {gb, ga, gc};
      vic_pkg::ORDER_CAB: level_order = {gc, ga, gb};
      vic_pkg::ORDER_CBA: level_order = {gc, gb, ga};
      vic_pkg::ORDER_ACB: level_order = {ga, gc, gb};
      default: level_order = {ga, gb, gc};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [vic_pkg::NUM_SOURCES-1:0] pend_q, pend_d, hw_clr;
  logic [vic_pkg::NUM_LEVELS-1:0] lvl_pend_q, lvl_pend_d;
  logic gie_q, gie_d;
  logic req_valid_q, req_valid_d;
  vic_pkg::request_type req_q, req_d;
  vic_pkg::seq_state_type state_q, state_d;
  logic [vic_pkg::ADDR_W-1:0] pc_q, pc_d, sp_q, sp_d;
  logic [vic_pkg::DATA_W-1:0] flags_q, flags_d, hi_q, hi_d;
  logic [vic_pkg::VEC_W-1:0] vec_q, vec_d;
  vic_pkg::mem_cmd_type cmd_q, cmd_d;
  logic [vic_pkg::ADDR_W-1:0] sp_out_q, sp_out_d, addr_q, addr_d;
  logic sp_load_q, sp_load_d, start_q, start_d;
  logic accept;
  logic found;
  logic [2:0] sel_lvl;
  logic [vic_pkg::SRC_W-1:0] sel_src;
  logic [23:0] order;
  logic [vic_pkg::NUM_SOURCES-1:0] lvl_peer;

  assign accept = req_valid_q && grant_in && (state_q == vic_pkg::ST_IDLE);

  // ----------------------------------------------------------------------
  // per source pending flags
  // ----------------------------------------------------------------------
  // hardware clear of the serviced source, per entry
  generate
    for (genvar g = 0; g < vic_pkg::NUM_SOURCES; g++) begin : g_src
      assign hw_clr[g] = accept && AUTO_CLEAR[g] &&
                         (req_q.source == vic_pkg::SRC_W'(g));
      // sources that share the level of the presented request
      assign lvl_peer[g] = (vic_pkg::LEVEL_OF[g] == req_q.level);
    end
  endgenerate

  // set by pin or counter event, set wins over either clear
  always_comb begin
    pend_d = (pend_q & ~source_clear_in & ~hw_clr) |
             source_event_in;
    lvl_pend_d = '0;
    for (int s = 0; s < vic_pkg::NUM_SOURCES; s++) begin
      if (pend_d[s]) begin
        lvl_pend_d[vic_pkg::LEVEL_OF[s]] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // global enable, bit 0 of system mode
  // ----------------------------------------------------------------------
  always_comb begin
    gie_d = gie_q;
    if (enable_interrupts_in) begin
      gie_d = 1'b1;
    end
    if (disable_interrupts_in) begin
      gie_d = 1'b0;
    end
    if (accept) begin
      gie_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // selection of level and vector
  // ----------------------------------------------------------------------
  always_comb begin
    order = level_order(level_priority_in);
    found = 1'b0;
    sel_lvl = '0;
    for (int k = 0; k < vic_pkg::NUM_LEVELS; k++) begin
      if (!found && lvl_pend_q[order[23-3*k -: 3]] &&
          level_mask_in[order[23-3*k -: 3]]) begin
        found = 1'b1;
        sel_lvl = order[23-3*k -: 3];
      end
    end
    // any count of vectors per level, lowest address kept last
    sel_src = '0;
    for (int s = vic_pkg::NUM_SOURCES - 1; s >= 0; s--) begin
      if (pend_q[s] && (vic_pkg::LEVEL_OF[s] == sel_lvl)) begin
        sel_src = vic_pkg::SRC_W'(s);
      end
    end
    req_d.level = sel_lvl;
    req_d.source = sel_src;
    req_d.vector = vic_pkg::VECTOR_OF[sel_src];
    req_valid_d = found && gie_d && (state_d == vic_pkg::ST_IDLE);
  end

  // ----------------------------------------------------------------------
  // service sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    flags_d = flags_q;
    sp_d = sp_q;
    vec_d = vec_q;
    hi_d = hi_q;
    addr_d = addr_q;
    sp_out_d = sp_out_q;
    sp_load_d = 1'b0;
    start_d = 1'b0;
    case (state_q)
      vic_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = vic_pkg::ST_PUSH_LO;
          pc_d = pc_in;
          flags_d = flags_in;
          sp_d = sp_in;
          vec_d = req_q.vector;
        end
      end
      vic_pkg::ST_PUSH_LO: state_d = vic_pkg::ST_PUSH_HI;
      vic_pkg::ST_PUSH_HI: state_d = vic_pkg::ST_PUSH_FL;
      vic_pkg::ST_PUSH_FL: state_d = vic_pkg::ST_FETCH_HI;
      vic_pkg::ST_FETCH_HI: state_d = vic_pkg::ST_FETCH_LO;
      vic_pkg::ST_FETCH_LO: begin
        hi_d = mem_rdata_in;
        state_d = vic_pkg::ST_START;
      end
      vic_pkg::ST_START: begin
        addr_d = {hi_q, mem_rdata_in};
        start_d = 1'b1;
        sp_out_d = sp_q - vic_pkg::PUSH_THREE;
        sp_load_d = 1'b1;
        state_d = vic_pkg::ST_IDLE;
      end
      default: state_d = vic_pkg::ST_IDLE;
    endcase
  end

  // memory command for the cycle that follows
  always_comb begin
    cmd_d = '0;
    case (state_d)
      vic_pkg::ST_PUSH_LO: begin
        cmd_d.addr = sp_d - vic_pkg::PUSH_ONE;
        cmd_d.wdata = pc_d[7:0];
        cmd_d.write = 1'b1;
      end
      vic_pkg::ST_PUSH_HI: begin
        cmd_d.addr = sp_d - vic_pkg::PUSH_TWO;
        cmd_d.wdata = pc_d[15:8];
        cmd_d.write = 1'b1;
      end
      vic_pkg::ST_PUSH_FL: begin
        cmd_d.addr = sp_d - vic_pkg::PUSH_THREE;
        cmd_d.wdata = flags_d;
        cmd_d.write = 1'b1;
      end
      vic_pkg::ST_FETCH_HI: begin
        cmd_d.addr = {vic_pkg::VECTOR_PAGE, vec_d};
        cmd_d.read = 1'b1;
      end
      vic_pkg::ST_FETCH_LO: begin
        cmd_d.addr = {vic_pkg::VECTOR_PAGE, vec_d} + vic_pkg::ADDR_ONE;
        cmd_d.read = 1'b1;
      end
      default: cmd_d = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q <= '0;
      lvl_pend_q <= '0;
      gie_q <= 1'b0;
      req_valid_q <= 1'b0;
      req_q <= '0;
      state_q <= vic_pkg::ST_IDLE;
      pc_q <= '0;
      flags_q <= '0;
      sp_q <= '0;
      vec_q <= '0;
      hi_q <= '0;
      cmd_q <= '0;
      addr_q <= '0;
      sp_out_q <= '0;
      sp_load_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      lvl_pend_q <= lvl_pend_d;
      gie_q <= gie_d;
      req_valid_q <= req_valid_d;
      req_q <= req_d;
      state_q <= state_d;
      pc_q <= pc_d;
      flags_q <= flags_d;
      sp_q <= sp_d;
      vec_q <= vec_d;
      hi_q <= hi_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      sp_out_q <= sp_out_d;
      sp_load_q <= sp_load_d;
      start_q <= start_d;
    end
  end

  // outputs straight from flip-flops, except busy_out decoded from state_q
  assign request_valid_out = req_valid_q;
  assign request_out = req_q;
  assign mem_cmd_out = cmd_q;
  assign sp_out = sp_out_q;
  assign sp_load_out = sp_load_q;
  assign service_addr_out = addr_q;
  assign service_start_out = start_q;
  assign global_enable_out = gie_q;
  assign level_pending_out = lvl_pend_q;
  assign source_pending_out = pend_q;
  assign busy_out = (state_q != vic_pkg::ST_IDLE);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_push;
    cmd_q.write && cmd_q.addr == sp_q - vic_pkg::PUSH_ONE &&
    cmd_q.wdata == pc_q[7:0] ##1
    cmd_q.write && cmd_q.addr == sp_q - vic_pkg::PUSH_TWO &&
    cmd_q.wdata == pc_q[15:8] ##1
    cmd_q.write && cmd_q.addr == sp_q - vic_pkg::PUSH_THREE &&
    cmd_q.wdata == flags_q;
  endsequence

  sequence s_fetch;
    cmd_q.read && cmd_q.addr == {vic_pkg::VECTOR_PAGE, vec_q} ##1
    cmd_q.read &&
    cmd_q.addr == {vic_pkg::VECTOR_PAGE, vec_q} + vic_pkg::ADDR_ONE;
  endsequence

  a_req_needs_enable: assert property (
    req_valid_q |-> gie_q && lvl_pend_q[req_q.level])
    else $error("request without enable or pending level");
  a_req_unmasked: assert property (
    req_valid_q |->
    (($past(level_mask_in) >> req_q.level) & 8'h01) == 8'h01)
    else $error("masked level presented to core");
  a_grant_disables: assert property (
    accept |=> !gie_q && !req_valid_q [*7])
    else $error("interrupts left enabled after grant");
  a_push_stack: assert property (
    accept |=> s_push)
    else $error("pc and flags not stacked in order");
  a_fetch_vector: assert property (
    accept |=> ##3 s_fetch)
    else $error("vector bytes not fetched in order");
  a_start_addr: assert property (
    accept |-> ##7 start_q && sp_load_q &&
    addr_q == {$past(mem_rdata_in, 2), $past(mem_rdata_in)})
    else $error("service address or start timing wrong");
  a_enable_instr: assert property (
    enable_interrupts_in && !disable_interrupts_in && !accept |=> gie_q)
    else $error("enable instruction ignored");
  a_disable_instr: assert property (
    disable_interrupts_in |=> !gie_q)
    else $error("disable instruction ignored");
  a_set_wins: assert property (
    source_event_in != '0 |=>
    (pend_q & $past(source_event_in)) == $past(source_event_in))
    else $error("source event lost");
  a_lowest_vector: assert property (
    req_valid_q |-> req_q.vector == vic_pkg::VECTOR_OF[req_q.source] &&
    vic_pkg::LEVEL_OF[req_q.source] == req_q.level &&
    ($past(pend_q) & lvl_peer &
     ((31'h0000_0001 << req_q.source) - 31'h0000_0001)) == '0)
    else $error("wrong vector chosen inside level");

endmodule

// ---- placeholder_unused.sv ----
`timescale 1ns/1ps

// ---- core_model.sv ----
`timescale 1ns/1ps
// stand-in for the processor core: grants requests, answers vector reads
module core_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic request_valid_in,
  input wire logic busy_in,
  input wire vic_pkg::mem_cmd_type mem_cmd_in,
  input wire logic grant_enable_in,
  input wire logic slow_in,
  output logic grant_out,
  output logic [7:0] mem_rdata_out
);
  logic grant_q;
  logic [2:0] wait_q;
  logic [7:0] rdata_q;
  logic [7:0] stack_mem [0:1023];

  // ----------------------------------------------------------------------
  // grant
  // ----------------------------------------------------------------------
  // one-cycle grant, prompt or after four cycles of delay
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      grant_q <= 1'b0;
      wait_q <= 3'h0;
    end else begin
      grant_q <= 1'b0;
      if (request_valid_in && !busy_in && grant_enable_in && !grant_q) begin
        if (!slow_in || wait_q == 3'h4) begin
          grant_q <= 1'b1;
          wait_q <= 3'h0;
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
  assign grant_out = grant_q;

  // ----------------------------------------------------------------------
  // memory
  // ----------------------------------------------------------------------
  // read data one cycle later; an idle bus flips so stale data never holds
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) rdata_q <= 8'h00;
    else if (mem_cmd_in.read) rdata_q <= mem_cmd_in.addr[7:0] ^ 8'hA5;
    else rdata_q <= ~rdata_q;
  end
  assign mem_rdata_out = rdata_q;

  // stack writes kept for the bench to inspect
  always_ff @(posedge clock_in) begin
    if (mem_cmd_in.write) begin
      stack_mem[mem_cmd_in.addr[9:0]] <= mem_cmd_in.wdata;
    end
  end
endmodule

// ---- vectored_interrupt_structure_bench.sv ----
`timescale 1ns/1ps
module vectored_interrupt_structure_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [30:0] source_event_in = '0;
  logic [30:0] source_clear_in = '0;
  logic [7:0] level_mask_in = 8'hFF;
  logic [7:0] level_priority_in = 8'h00;
  logic enable_interrupts_in = 1'b0;
  logic disable_interrupts_in = 1'b0;
  logic grant_in;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] flags_in = 8'h00;
  logic [15:0] sp_in = 16'h0000;
  logic [7:0] mem_rdata_in;
  logic request_valid_out;
  vic_pkg::request_type request_out;
  vic_pkg::mem_cmd_type mem_cmd_out;
  logic [15:0] sp_out;
  logic sp_load_out;
  logic [15:0] service_addr_out;
  logic service_start_out;
  logic global_enable_out;
  logic [7:0] level_pending_out;
  logic [30:0] source_pending_out;
  logic busy_out;
  logic grant_enable = 1'b0;
  logic slow = 1'b0;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] pri_t [0:21] = '{8'h00, 8'h02, 8'h10, 8'h12, 8'h80, 8'h82,
    8'h90, 8'h92, 8'h02, 8'h12, 8'h10, 8'h90, 8'h80, 8'h82, 8'h00, 8'h01,
    8'h00, 8'h04, 8'h0C, 8'h00, 8'h20, 8'h60};
  logic [30:0] ev_t [0:21] = '{31'h0000_0809, 31'h0000_0809, 31'h0000_0809,
    31'h0000_0809, 31'h0000_0809, 31'h0000_0809, 31'h0000_0809,
    31'h0000_0809, 31'h0000_0801, 31'h0000_0801, 31'h0000_0808,
    31'h0000_0808, 31'h0000_0009, 31'h0000_0009, 31'h0000_0005,
    31'h0000_0005, 31'h0000_0228, 31'h0000_0228, 31'h0000_0228,
    31'h0080_8800, 31'h0080_8800, 31'h0080_8800};
  logic [2:0] lv_t [0:21] = '{3'h0, 3'h2, 3'h0, 3'h2, 3'h5, 3'h5, 3'h0,
    3'h0, 3'h5, 3'h0, 3'h2, 3'h5, 3'h0, 3'h2, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
    3'h5, 3'h6, 3'h7};

  always #4 clock_in = ~clock_in;

  vectored_interrupt_structure vectored_interrupt_structure_inst (
    .clock_in(clock_in), .rst_in(rst_in), .source_event_in(source_event_in),
    .source_clear_in(source_clear_in), .level_mask_in(level_mask_in),
    .level_priority_in(level_priority_in),
    .enable_interrupts_in(enable_interrupts_in),
    .disable_interrupts_in(disable_interrupts_in), .grant_in(grant_in),
    .pc_in(pc_in), .flags_in(flags_in), .sp_in(sp_in),
    .mem_rdata_in(mem_rdata_in), .request_valid_out(request_valid_out),
    .request_out(request_out), .mem_cmd_out(mem_cmd_out), .sp_out(sp_out),
    .sp_load_out(sp_load_out), .service_addr_out(service_addr_out),
    .service_start_out(service_start_out),
    .global_enable_out(global_enable_out),
    .level_pending_out(level_pending_out),
    .source_pending_out(source_pending_out), .busy_out(busy_out));

  core_model core_model_inst (
    .clock_in(clock_in), .rst_in(rst_in),
    .request_valid_in(request_valid_out), .busy_in(busy_out),
    .mem_cmd_in(mem_cmd_out), .grant_enable_in(grant_enable),
    .slow_in(slow), .grant_out(grant_in), .mem_rdata_out(mem_rdata_in));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clock_in);
    #1;
  endtask

  // one cycle of events, clears and instruction pulses
  task automatic drive(input logic [30:0] ev, input logic [30:0] clr,
                       input logic en, input logic dis);
    source_event_in = ev;
    source_clear_in = clr;
    enable_interrupts_in = en;
    disable_interrupts_in = dis;
    step();
    source_event_in = '0;
    source_clear_in = '0;
    enable_interrupts_in = 1'b0;
    disable_interrupts_in = 1'b0;
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (request_valid_out !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (request_valid_out !== 1'b1) begin
      check("request_wait", 32'h0, 32'h1);
      final_report();
    end
  endtask

  // enable, let the core grant, follow the service sequence to its start
  task automatic serve(input int s);
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] fl;
    logic [7:0] vec;
    logic [9:0] st;
    int n;
    int g;
    vec = vic_pkg::VECTOR_OF[s];
    pc = 16'hC300 + 16'(s);
    sp = 16'h0200 + 16'(s * 8);
    fl = 8'h40 + 8'(s);
    st = sp[9:0];
    g = 0;
    pc_in = pc;
    sp_in = sp;
    flags_in = fl;
    drive('0, '0, 1'b1, 1'b0);
    wait_req();
    check("request_source", request_out.source, s);
    check("request_vector", request_out.vector, vec);
    grant_enable = 1'b1;
    n = 0;
    while (service_start_out !== 1'b1 && n < 40) begin
      if (grant_in === 1'b1) g = n;
      step();
      n++;
    end
    grant_enable = 1'b0;
    if (service_start_out !== 1'b1) begin
      check("start_wait", 32'h0, 32'h1);
      final_report();
    end
    check("start_latency", n - g, 7);
    check("busy_at_start", busy_out, 1'b0);
    check("service_addr", service_addr_out,
          {vec ^ 8'hA5, (vec + 8'h01) ^ 8'hA5});
    check("sp_out", sp_out, sp - 16'h0003);
    check("sp_load", sp_load_out, 1'b1);
    check("push_pc_lo", core_model_inst.stack_mem[st - 10'h001],
          pc[7:0]);
    check("push_pc_hi", core_model_inst.stack_mem[st - 10'h002],
          pc[15:8]);
    check("push_flags", core_model_inst.stack_mem[st - 10'h003],
          fl);
    check("gie_after_grant", global_enable_out, 1'b0);
    check("request_after_grant", request_valid_out, 1'b0);
    check("hw_clear", source_pending_out[s],
          !vic_pkg::AUTO_CLEAR_DEFAULT[s]);
    drive('0, 31'(1) << s, 1'b0, 1'b0);
    check("sw_clear", source_pending_out[s], 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    check("reset_request", request_valid_out, 1'b0);
    check("reset_gie", global_enable_out, 1'b0);
    check("reset_levels", level_pending_out, 8'h00);
    check("reset_busy", busy_out, 1'b0);
    // pending without global enable stays off the core
    drive(31'h0000_0001, '0, 1'b0, 1'b0);
    repeat (3) step();
    check("no_gie_request", request_valid_out, 1'b0);
    drive('0, 31'h7FFF_FFFF, 1'b0, 1'b0);
    // every source alone: its level and its own vector
    for (int s = 0; s < 31; s++) begin
      drive(31'(1) << s, '0, 1'b1, 1'b0);
      check("source_pending", source_pending_out, 31'(1) << s);
      check("level_pending", level_pending_out,
            8'(1) << vic_pkg::LEVEL_OF[s]);
      wait_req();
      check("single_level", request_out.level, vic_pkg::LEVEL_OF[s]);
      check("single_vector", request_out.vector,
            vic_pkg::VECTOR_OF[s]);
      drive('0, 31'h7FFF_FFFF, 1'b0, 1'b1);
    end
    // level priority settings, groups and subgroups
    for (int i = 0; i < 22; i++) begin
      level_priority_in = pri_t[i];
      drive(ev_t[i], '0, 1'b1, 1'b0);
      wait_req();
      check("priority_level", request_out.level, lv_t[i]);
      drive('0, 31'h7FFF_FFFF, 1'b0, 1'b1);
    end
    level_priority_in = 8'h00;
    // mask, then unmask, then global disable
    level_mask_in = 8'hEF;
    drive(31'h0000_0200, '0, 1'b1, 1'b0);
    repeat (4) step();
    check("masked_level", request_valid_out, 1'b0);
    level_mask_in = 8'hFF;
    wait_req();
    check("unmasked_level", request_out.level, 3'h4);
    drive('0, '0, 1'b0, 1'b1);
    step();
    check("disable_gie", global_enable_out, 1'b0);
    check("disable_request", request_valid_out, 1'b0);
    drive('0, '0, 1'b1, 1'b1);
    step();
    check("disable_wins", global_enable_out, 1'b0);
    drive('0, 31'h7FFF_FFFF, 1'b0, 1'b0);
    // level 0, two vectors, slow grant: lowest vector first
    slow = 1'b1;
    drive(31'h0000_0003, '0, 1'b0, 1'b0);
    serve(0);
    serve(1);
    // level 3, four vectors, prompt grant, in ascending vector order
    slow = 1'b0;
    drive(31'h0000_01E0, '0, 1'b0, 1'b0);
    for (int s = 5; s < 9; s++) serve(s);
    // single vector level
    drive(31'h0000_0004, '0, 1'b0, 1'b0);
    serve(2);
    final_report();
  end
endmodule
